// File: rtl/wmt_marker_trigger_top.sv
// marker and trigger output core: sequencer, playback queue, connectors
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module wmt_marker_trigger_top #(
  parameter int SEQ_DIV = wmt_pkg::SEQ_DIV,
  parameter int FIFO_DEPTH = wmt_pkg::FIFO_DEPTH,
  parameter int N_CONN = wmt_pkg::N_CONN
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic [1:0] digTrigIn,
  output logic [wmt_pkg::ANALOG_W-1:0] analogOut,
  output logic [1:0] markerOut,
  output logic [3:0] trigOut,
  output logic [N_CONN-1:0] connOut,
  output logic oscPhaseClear,
  output logic [15:0] lowBandFreq,
  output logic instrReady,
  output logic playing
);
  import wmt_pkg::*;

  // first marker in bit 0 of the returned pair
  function automatic logic [1:0] markerDecode(input logic [1:0] code);
    logic [1:0] m;
    m = 2'h0;
    case (code)
      2'h1: m = 2'h1;
      2'h2: m = 2'h2;
      2'h3: m = 2'h3;
      default: m = 2'h0;
    endcase
    return m;
  endfunction : markerDecode

  function automatic logic [SAMPLE_W-1:0] mergeSamples(input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b);
    logic [ANALOG_W-1:0] an;
    logic [1:0] mk;
    an = a[ANALOG_W-1:0] + b[ANALOG_W-1:0];
    mk = a[SAMPLE_W-1:MARK_LSB] | b[SAMPLE_W-1:MARK_LSB];
    return {mk, an};
  endfunction : mergeSamples

  localparam int CW = $clog2(SEQ_DIV + 1);
  localparam int SW = $clog2(N_CONN * 3 + 1);

  logic [SAMPLE_W-1:0] wave [2**WAVE_AW];

  wmt_stream_if #(.WIDTH(INSTR_W)) pushIf ();
  wmt_stream_if #(.WIDTH(INSTR_W)) popIf ();

  wmt_fifo #(.WIDTH(INSTR_W), .DEPTH(FIFO_DEPTH)) uFifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .inS(pushIf.snk),
    .outS(popIf.src)
  );

  // register group
  logic run, next_run;
  logic [WAVE_AW-1:0] waveAddr, next_waveAddr;
  logic [N_CONN*3-1:0] connSel, next_connSel;
  logic [15:0] next_lowBandFreq;
  logic [31:0] next_regRdata;
  logic next_instrReady;
  logic waveWe;

  // sequencer and playback group
  wmt_state_e state, next_state;
  logic [CW-1:0] seqCnt, next_seqCnt;
  logic [3:0] trigBits, next_trigBits;
  logic [3:0] next_trigOut;
  logic pendV, next_pendV;
  wmt_entry_s pend, next_pend;
  logic active, next_active;
  logic curSilence, next_curSilence;
  logic curSum, next_curSum;
  logic [WAVE_AW-1:0] ptrA, ptrB, next_ptrA, next_ptrB;
  logic [10:0] remain, next_remain;
  logic [ANALOG_W-1:0] next_analogOut;
  logic [1:0] next_markerOut;
  logic next_oscPhaseClear;
  logic next_playing;
  logic trigSel, next_trigSel;
  logic trigFall, next_trigFall;
  logic [1:0] trigPrev;
  logic [N_CONN-1:0] next_connOut;

  logic seqTick, pendTaken, execNow, edgeSeen;
  logic [SAMPLE_W-1:0] sample;
  logic [INSTR_W-1:0] ins;
  wmt_op_e op;
  logic [6:0] lenU;

  assign pushIf.data = regWdata;
  assign pushIf.valid = regWr && (regAddr == REG_INSTR);
  assign ins = popIf.data;
  assign op = wmt_op_e'(ins[OP_MSB:OP_LSB]);
  assign waveWe = regWr && (regAddr == REG_WAVE_DATA);

  always_comb begin
    next_run = run;
    next_waveAddr = waveAddr;
    next_connSel = connSel;
    next_lowBandFreq = lowBandFreq;
    next_regRdata = 32'h0000_0000;
    next_instrReady = pushIf.ready && !pushIf.valid;
    if (regWr) begin
      case (regAddr)
        REG_CTRL: next_run = regWdata[0];
        REG_WAVE_ADDR: next_waveAddr = regWdata[WAVE_AW-1:0];
        REG_WAVE_DATA: next_waveAddr = waveAddr + 1'b1;
        REG_CONN_SEL: next_connSel = regWdata[N_CONN*3-1:0];
        REG_LOW_BAND: begin
          if ((regWdata[15:0] % LOW_BAND_STEP_MHZ) == 16'h0000) begin
            next_lowBandFreq = regWdata[15:0];
          end
        end
        default: next_run = run;
      endcase
    end
    if (regRd) begin
      case (regAddr)
        REG_CTRL: next_regRdata = {31'h0000_0000, run};
        REG_STATUS: next_regRdata = {23'h00_0000, state == ST_AWAIT, state == ST_HOLD, trigBits, pendV,
                                     !pushIf.ready, active};
        REG_WAVE_ADDR: next_regRdata = {{(32 - WAVE_AW){1'b0}}, waveAddr};
        REG_WAVE_DATA: next_regRdata = {16'h0000, wave[waveAddr]};
        REG_CONN_SEL: next_regRdata = {{(32 - N_CONN * 3){1'b0}}, connSel};
        REG_LOW_BAND: next_regRdata = {16'h0000, lowBandFreq};
        default: next_regRdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      run <= 1'b0;
      waveAddr <= '0;
      connSel <= CONN_SEL_RESET;
      lowBandFreq <= LOW_BAND_RESET;
      regRdata <= 32'h0000_0000;
      instrReady <= 1'b0;
    end else if (ce) begin
      run <= next_run;
      waveAddr <= next_waveAddr;
      connSel <= next_connSel;
      lowBandFreq <= next_lowBandFreq;
      regRdata <= next_regRdata;
      instrReady <= next_instrReady;
    end
  end

  // analog in bits 13:0, markers in 15:14
  always_ff @(posedge mclk) begin
    if (ce && waveWe) begin
      wave[waveAddr] <= regWdata[SAMPLE_W-1:0];
    end
  end

  always_comb begin
    seqTick = (seqCnt == CW'(SEQ_DIV - 1));
    next_seqCnt = seqTick ? '0 : seqCnt + 1'b1;
    next_state = state;
    next_trigBits = trigBits;
    next_trigOut = trigOut;
    next_pendV = pendV;
    next_pend = pend;
    next_active = active;
    next_curSilence = curSilence;
    next_curSum = curSum;
    next_ptrA = ptrA;
    next_ptrB = ptrB;
    next_remain = remain;
    next_oscPhaseClear = 1'b0;
    next_trigSel = trigSel;
    next_trigFall = trigFall;
    pendTaken = 1'b0;
    execNow = 1'b0;
    lenU = 7'h00;
    edgeSeen = trigFall ? (trigPrev[trigSel] && !digTrigIn[trigSel])
                        : (!trigPrev[trigSel] && digTrigIn[trigSel]);
    // marker and analog data for the sample now under the pointer
    sample = '0;
    if (curSilence) begin
      sample = '0;
    end else if (curSum) begin
      sample = mergeSamples(wave[ptrA], wave[ptrB]);
    end else begin
      sample = wave[ptrA];
    end
    next_analogOut = active ? sample[ANALOG_W-1:0] : '0;
    next_markerOut = active ? markerDecode(sample[SAMPLE_W-1:MARK_LSB]) : 2'h0;
    // playback: the pending entry takes over on the cycle after the last sample
    if (active && remain != 11'h001) begin
      next_remain = remain - 1'b1;
      next_ptrA = ptrA + 1'b1;
      next_ptrB = ptrB + 1'b1;
    end else if (pendV) begin
      pendTaken = 1'b1;
      next_active = 1'b1;
      next_curSilence = pend.silence;
      next_curSum = pend.sum;
      next_ptrA = pend.baseA;
      next_ptrB = pend.baseB;
      next_remain = {pend.lenUnits, 4'h0};
      next_pendV = 1'b0;
    end else begin
      next_active = 1'b0;
    end
    // sequencer steps on the coarse grid only
    if (seqTick) begin
      next_trigOut = trigBits;
    end
    case (state)
      ST_FETCH: begin
        if (seqTick && run && popIf.valid) begin
          execNow = 1'b1;
          case (op)
            OP_DRIVE_TRIGGER_BITS: begin
              next_trigBits = ins[3:0];
              next_trigOut = ins[3:0];
            end
            OP_PLAY_WAVEFORM, OP_PLAY_SILENCE: begin
              if (pendV && !pendTaken) begin
                execNow = 1'b0;
              end else begin
                lenU = ins[LEN_MSB:LEN_LSB];
                next_pendV = 1'b1;
                next_pend.silence = (op == OP_PLAY_SILENCE);
                next_pend.sum = ins[SUM_BIT];
                next_pend.baseA = ins[WAVE_AW-1:0];
                next_pend.baseB = ins[2*WAVE_AW-1:WAVE_AW];
                next_pend.lenUnits = (lenU < LEN_MIN_UNITS) ? LEN_MIN_UNITS : lenU;
              end
            end
            OP_HOLD_UNTIL_PLAYBACK_DONE: next_state = ST_HOLD;
            OP_AWAIT_DIGITAL_TRIGGER: begin
              next_trigSel = ins[0];
              next_trigFall = ins[1];
              next_state = ST_AWAIT;
            end
            OP_OSCILLATOR_PHASE_CLEAR: next_oscPhaseClear = 1'b1;
            default: next_state = ST_FETCH;
          endcase
        end
      end
      ST_HOLD: begin
        if (!active && !pendV) begin
          next_state = ST_FETCH;
        end
      end
      ST_AWAIT: begin
        if (edgeSeen) begin
          next_state = ST_FETCH;
        end
      end
      default: next_state = ST_FETCH;
    endcase
    next_playing = active; // frames the registered samples, one cycle behind active
  end

  assign popIf.ready = execNow;

  // connector source: codes 0..1 marker bits, 2..5 trigger bits
  generate
    for (genvar c = 0; c < N_CONN; c++) begin : gConn
      logic [2:0] sel;
      assign sel = connSel[c*3 +: 3];
      always_comb begin
        case (sel)
          3'h0: next_connOut[c] = next_markerOut[0];
          3'h1: next_connOut[c] = next_markerOut[1];
          3'h2: next_connOut[c] = next_trigOut[0];
          3'h3: next_connOut[c] = next_trigOut[1];
          3'h4: next_connOut[c] = next_trigOut[2];
          3'h5: next_connOut[c] = next_trigOut[3];
          default: next_connOut[c] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_FETCH;
      seqCnt <= '0;
      trigBits <= 4'h0;
      trigOut <= 4'h0;
      pendV <= 1'b0;
      pend <= '0;
      active <= 1'b0;
      curSilence <= 1'b0;
      curSum <= 1'b0;
      ptrA <= '0;
      ptrB <= '0;
      remain <= '0;
      analogOut <= '0;
      markerOut <= 2'h0;
      oscPhaseClear <= 1'b0;
      trigSel <= 1'b0;
      trigFall <= 1'b0;
      trigPrev <= 2'h0;
      connOut <= '0;
      playing <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      seqCnt <= next_seqCnt;
      trigBits <= next_trigBits;
      trigOut <= next_trigOut;
      pendV <= next_pendV;
      pend <= next_pend;
      active <= next_active;
      curSilence <= next_curSilence;
      curSum <= next_curSum;
      ptrA <= next_ptrA;
      ptrB <= next_ptrB;
      remain <= next_remain;
      analogOut <= next_analogOut;
      markerOut <= next_markerOut;
      oscPhaseClear <= next_oscPhaseClear;
      trigSel <= next_trigSel;
      trigFall <= next_trigFall;
      trigPrev <= digTrigIn;
      connOut <= next_connOut;
      playing <= next_playing;
    end
  end
endmodule : wmt_marker_trigger_top

// File: rtl/wmt_pkg.sv
// shared constants and types of the waveform marker and trigger output block
//
// Notes on behaviour
// - each sample word is 16 bits: 14 analog bits plus two marker bits
// - marker bits are zero unless the waveform sets them
// - trigger bits move on the sequencer grid, markers every sample
// - marker code 0 both low, 1 first, 2 second, 3 both high
// - summed waveforms add analog data and merge markers into one stream
// - merged marker bits combine by bitwise OR
// - markers return to zero once nothing plays
// - the core owns four sequencer-set trigger state bits
// - trigger-set loads four bits, bit 0 drives trigger output 1
// - hold-until-done stalls the next control instruction until playback ends
// - without a hold, the instruction after a play runs at playback start
// - queued waveforms and silences play back to back without gaps
// - each digital connector selects a marker bit or a trigger bit
// - a trigger raised right before a play rises at playback start; here trigOut rises SEQ_DIV + 2 cycles before playing
// - low band center frequency only accepted in 100 MHz multiples
// - phase clear after trigger wait gives reproducible start phase
// - lengths in 16-sample units, at least 32 samples
// - digital trigger wait stalls until the chosen input shows the chosen edge
package wmt_pkg;
  localparam int CLK_PS = 10000;
  localparam int SEQ_PS = 4000;
  localparam int SAMPLE_PS = 500;
  localparam int SEQ_DIV = SEQ_PS / SAMPLE_PS;
  localparam int FIFO_DEPTH = 16;
  localparam int INSTR_W = 32;
  localparam int WAVE_AW = 8;
  localparam int N_CONN = 4;
  localparam int SAMPLE_W = 16;
  localparam int ANALOG_W = 14;
  localparam int MARK_LSB = 14;
  localparam int LEN_UNIT_LOG2 = 4;
  localparam logic [6:0] LEN_MIN_UNITS = 7'h02;
  localparam logic [15:0] LOW_BAND_STEP_MHZ = 16'h0064;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INSTR = 8'h08;
  localparam logic [7:0] REG_WAVE_ADDR = 8'h0C;
  localparam logic [7:0] REG_WAVE_DATA = 8'h10;
  localparam logic [7:0] REG_CONN_SEL = 8'h14;
  localparam logic [7:0] REG_LOW_BAND = 8'h18;
  localparam logic [11:0] CONN_SEL_RESET = 12'h000;
  localparam logic [15:0] LOW_BAND_RESET = 16'h0000;
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 28;
  localparam int LEN_MSB = 23;
  localparam int LEN_LSB = 17;
  localparam int SUM_BIT = 16;
  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_DRIVE_TRIGGER_BITS = 4'h1,
    OP_PLAY_WAVEFORM = 4'h2,
    OP_PLAY_SILENCE = 4'h3,
    OP_HOLD_UNTIL_PLAYBACK_DONE = 4'h4,
    OP_AWAIT_DIGITAL_TRIGGER = 4'h5,
    OP_OSCILLATOR_PHASE_CLEAR = 4'h6
  } wmt_op_e;
  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_HOLD = 3'b010,
    ST_AWAIT = 3'b100
  } wmt_state_e;
  typedef struct packed {
    logic silence;
    logic sum;
    logic [WAVE_AW-1:0] baseA;
    logic [WAVE_AW-1:0] baseB;
    logic [6:0] lenUnits;
  } wmt_entry_s;
endpackage : wmt_pkg

// File: rtl/wmt_stream_if.sv
// valid/ready word stream between the block's own modules
`timescale 1ns/1ps
interface wmt_stream_if #(parameter int WIDTH = 32);
  logic [WIDTH-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : wmt_stream_if

// File: rtl/wmt_fifo.sv
// instruction fifo with parameterised width and depth
`timescale 1ns/1ps
module wmt_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  wmt_stream_if.snk inS,
  wmt_stream_if.src outS
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic [AW:0] count, next_count;
  logic push, pop;

  always_comb begin
    push = inS.valid && (count != (AW + 1)'(DEPTH));
    pop = outS.ready && (count != '0);
    next_wrPtr = push ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = pop ? rdPtr + 1'b1 : rdPtr;
    next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else if (ce) begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  always_ff @(posedge mclk) begin
    if (ce && push) begin
      mem[wrPtr] <= inS.data;
    end
  end

  assign inS.ready = (count != (AW + 1)'(DEPTH));
  assign outS.valid = (count != '0);
  assign outS.data = mem[rdPtr];
endmodule : wmt_fifo

// File: tb/wmt_marker_trigger_asserts.sv
// port-level checks of the marker and trigger output core
`timescale 1ns/1ps
module wmt_marker_trigger_asserts #(
  parameter int SEQ_DIV = 8,
  parameter int FIFO_DEPTH = 16,
  parameter int N_CONN = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic [wmt_pkg::ANALOG_W-1:0] analogOut,
  input wire logic [1:0] markerOut,
  input wire logic [3:0] trigOut,
  input wire logic oscPhaseClear,
  input wire logic [15:0] lowBandFreq,
  input wire logic playing
);
  import wmt_pkg::*;
  logic [15:0] playCnt;
  logic [15:0] next_playCnt;
  logic [15:0] wdLow;
  assign wdLow = regWdata[15:0];
  // length of the current unbroken playback run
  always_comb begin
    next_playCnt = playing ? playCnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      playCnt <= 16'h0000;
    end else if (ce) begin
      playCnt <= next_playCnt;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_idle_quiet;
    !playing |-> markerOut == 2'h0 && analogOut == '0;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("outputs not zero while idle");
  property p_trig_grid;
    $changed(trigOut) |=> $stable(trigOut) [*7];
  endproperty
  a_trig_grid: assert property (p_trig_grid) else $error("trigger bits moved off the grid");
  property p_phase_pulse;
    oscPhaseClear && ce |=> !oscPhaseClear [*7];
  endproperty
  a_phase_pulse: assert property (p_phase_pulse) else $error("phase clear pulse too long");
  property p_low_band;
    $changed(lowBandFreq) |-> $past(regWr) && $past(regAddr) == REG_LOW_BAND && lowBandFreq == $past(wdLow)
      && lowBandFreq % LOW_BAND_STEP_MHZ == 16'h0000;
  endproperty
  a_low_band: assert property (p_low_band) else $error("bad low band frequency update");
  property p_play_len;
    $fell(playing) |-> playCnt >= 16'h0020 && playCnt[3:0] == 4'h0;
  endproperty
  a_play_len: assert property (p_play_len) else $error("playback length off granularity");
  property p_rd_quiet;
    ce && !regRd |=> regRdata == 32'h0;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
  property p_rd_unmapped;
    ce && regRd && regAddr == 8'h1C |=> regRdata == 32'h0;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
  property p_freeze;
    !ce |=> $stable(trigOut) && $stable(markerOut) && $stable(playing);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
  c_play: cover property ($rose(playing));
  c_trig: cover property ($changed(trigOut));
  c_phase: cover property (oscPhaseClear);
endmodule : wmt_marker_trigger_asserts
bind wmt_marker_trigger_top wmt_marker_trigger_asserts #(.SEQ_DIV(SEQ_DIV), .FIFO_DEPTH(FIFO_DEPTH),
  .N_CONN(N_CONN)) i_asserts (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .analogOut(analogOut),
  .markerOut(markerOut), .trigOut(trigOut), .oscPhaseClear(oscPhaseClear), .lowBandFreq(lowBandFreq),
  .playing(playing));

// File: tb/wmt_ttl_equipment.sv
// test equipment model: digital trigger source and ttl edge counter
`timescale 1ns/1ps
module wmt_ttl_equipment #(
  parameter int N_CONN = 4
) (
  input wire logic mclk,
  input wire logic fire,
  input wire logic [3:0] fireDelay,
  input wire logic [N_CONN-1:0] connIn,
  output logic [1:0] trigLine,
  output logic [7:0] riseCount
);
  logic [4:0] delayLeft = 5'h00;
  logic lastConn = 1'b0;
  initial begin
    trigLine = 2'h0;
    riseCount = 8'h00;
  end
  always @(posedge mclk) begin
    lastConn <= connIn[0];
    if (connIn[0] === 1'b1 && lastConn === 1'b0) begin
      riseCount <= riseCount + 8'h01;
    end
    // edge comes out promptly or after a few cycles
    if (fire) begin
      delayLeft <= {1'b0, fireDelay} + 5'h01;
    end else if (delayLeft == 5'h01) begin
      trigLine[0] <= ~trigLine[0];
      delayLeft <= 5'h00;
    end else if (delayLeft != 5'h00) begin
      delayLeft <= delayLeft - 5'h01;
    end
  end
endmodule : wmt_ttl_equipment

// File: tb/test_waveform_marker_trigger_output.sv
// self-checking bench of the marker and trigger output core
`timescale 1ns/1ps
module test_waveform_marker_trigger_output;
  import wmt_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic [1:0] digTrigIn;
  logic [ANALOG_W-1:0] analogOut;
  logic [1:0] markerOut;
  logic [3:0] trigOut;
  logic [N_CONN-1:0] connOut;
  logic oscPhaseClear;
  logic [15:0] lowBandFreq;
  logic instrReady;
  logic playing;
  logic fire = 1'b0;
  logic [3:0] fireDelay = 4'h0;
  logic [7:0] riseCount;
  logic [15:0] wA [32];
  logic [15:0] wB [32];
  logic [15:0] cur;
  logic [15:0] prv;
  logic [31:0] r;
  logic [31:0] prog [9] = '{32'h1000_0003, 32'h2005_2000, 32'h3004_0000, 32'h1000_0000, 32'h4000_0000,
    32'h1000_0009, 32'h6000_0000, 32'h5000_0000, 32'h1000_0006};
  int nErrors = 0;
  int totalChecks = 0;
  int cycles = 0;
  int rises = 0;
  always #5 mclk = ~mclk;
  wmt_marker_trigger_top i_wmt_marker_trigger_top (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .digTrigIn(digTrigIn),
    .analogOut(analogOut), .markerOut(markerOut), .trigOut(trigOut), .connOut(connOut),
    .oscPhaseClear(oscPhaseClear), .lowBandFreq(lowBandFreq), .instrReady(instrReady), .playing(playing));
  wmt_ttl_equipment #(.N_CONN(N_CONN)) i_wmt_ttl_equipment (.mclk(mclk), .fire(fire), .fireDelay(fireDelay),
    .connIn(connOut), .trigLine(digTrigIn), .riseCount(riseCount));
  task automatic finishTest();
    if (nErrors == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finishTest
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      nErrors++;
      finishTest();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    chk(name, exp, regRdata);
  endtask : rd
  function automatic logic [31:0] probe(input int sel);
    case (sel)
      0: probe = {28'h0, trigOut};
      1: probe = {31'h0, playing};
      default: probe = {31'h0, oscPhaseClear};
    endcase
  endfunction : probe
  task automatic waitFor(input int sel, input logic [31:0] exp, input int lim, input string name);
    int k;
    k = 0;
    @(negedge mclk);
    while (probe(sel) !== exp && k < lim) begin
      @(negedge mclk);
      k++;
    end
    chk(name, exp, probe(sel));
  endtask : waitFor
  // summed entry: analog adds with wrap, markers merge by or
  function automatic logic [15:0] expSample(input int i);
    if (i >= 32) return 16'h0000;
    return {wA[i][15:14] | wB[i][15:14], wA[i][13:0] + wB[i][13:0]};
  endfunction : expSample
  initial begin
    void'($urandom(32'h5e88a33d));
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(REG_CONN_SEL, {20'h0, CONN_SEL_RESET}, "connSel");
    rd(REG_STATUS, 32'h0, "status");
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0, "unmapped");
    r = ($urandom % 600) * 100;
    wr(REG_LOW_BAND, r);
    wr(REG_LOW_BAND, r + 32'd1);
    rd(REG_LOW_BAND, r, "lowBand");
    chk("lowBandFreq", r, {16'h0, lowBandFreq});
    wr(REG_WAVE_ADDR, 32'h0);
    for (int i = 0; i < 32; i++) begin
      wA[i] = {i[1:0], 14'($urandom)};
      wB[i] = {2'($urandom), 14'($urandom)};
    end
    for (int i = 0; i < 64; i++) wr(REG_WAVE_DATA, {16'h0, i < 32 ? wA[i] : wB[i - 32]});
    wr(REG_WAVE_ADDR, 32'd5);
    rd(REG_WAVE_DATA, {16'h0, wA[5]}, "waveWord");
    wr(REG_CONN_SEL, 32'h0000_0A88);
    wr(REG_CTRL, 32'h1);
    foreach (prog[i]) wr(REG_INSTR, prog[i]);
    waitFor(1, 32'h1, 400, "playing");
    chk("trigAtStart", 32'h3, {28'h0, trigOut});
    prv = 16'h0;
    for (int i = 0; i < 64; i++) begin
      cur = expSample(i);
      chk("sample", {16'h0, cur}, {16'h0, markerOut, analogOut});
      chk("playing", 32'h1, {31'h0, playing});
      if (cur[14] && !prv[14]) rises++;
      prv = cur;
      @(negedge mclk);
    end
    chk("playing", 32'h0, {31'h0, playing});
    chk("marker", 32'h0, {30'h0, markerOut});
    chk("trigOut", 32'h0, {28'h0, trigOut});
    waitFor(0, 32'h9, 40, "trigOut");
    @(negedge mclk);
    chk("conn", 32'hC, {28'h0, connOut});
    chk("rises", rises, {24'h0, riseCount});
    waitFor(2, 32'h1, 40, "phaseClear");
    repeat (30) @(negedge mclk);
    @(posedge mclk);
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    ce <= 1'b1;
    fire <= 1'b1;
    fireDelay <= 4'($urandom);
    @(posedge mclk);
    fire <= 1'b0;
    chk("trigOut", 32'h9, {28'h0, trigOut});
    waitFor(0, 32'h6, 60, "trigOut");
    for (int n = 0; n < 6; n++) begin
      r = 32'($urandom % 16);
      wr(REG_INSTR, 32'h1000_0000 | r);
      waitFor(0, r, 20, "trigOut");
    end
    wr(REG_CTRL, 32'h0);
    repeat (17) wr(REG_INSTR, 32'h0);
    rd(REG_STATUS, (r << 3) | 32'h2, "status");
    chk("instrReady", 32'h0, {31'h0, instrReady});
    wr(REG_CTRL, 32'h1);
    repeat (150) @(negedge mclk);
    rd(REG_STATUS, r << 3, "status");
    chk("instrReady", 32'h1, {31'h0, instrReady});
    wr(REG_INSTR, 32'h1000_0000 | (r ^ 32'hF));
    waitFor(0, r ^ 32'hF, 12, "trigOut");
    // falling-edge wait on the same input: the line now stands high
    wr(REG_INSTR, 32'h5000_0002);
    wr(REG_INSTR, 32'h1000_0000 | r);
    repeat (20) @(negedge mclk);
    chk("trigOut", r ^ 32'hF, {28'h0, trigOut});
    @(posedge mclk);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    waitFor(0, r, 60, "trigOut");
    finishTest();
  end
endmodule : test_waveform_marker_trigger_output
